/* design/hbg_gate_ctrl.sv */
/*
  Control logic of a two-channel half-bridge gate driver: pin defaults,
  on/off decoding, supply lockout, overlap clamp and dead-time insertion.
  Assumes all pins are synchronous levels except the two channel inputs,
  which are synchronised here; supply-good flags come from comparators.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbg_map.svh"

// Summary of operation
// - Primary supply low holds both gate drives low, nothing passes.
// - Primary lockout overrides channel, enable and shutdown inputs alike.
// - A channel supply in lockout forces only that gate drive low.
// - A healthy channel keeps following its input during other's lockout.
// - Enable and both channel inputs are active high.
// - The shutdown input is active high.
// - Shutdown high with enable low disables, both gate drives low.
// - A floating channel input reads low, keeping its gate drive low.
// - A floating enable input reads high.
// - A floating shutdown input reads low, so floating pins run normally.
// - A drive rises only for own input high, other low, after the gap.
// - Both inputs high clamp both drives low until either falls.
// - Every low-to-high drive transition waits for the dead time.
// - Dead time is the longer of configured gap and input gap.
module hbg_gate_ctrl (
  input wire logic CLOCK,                     // 200 MHz internal clock
  input wire logic RST_N,                     // Power-good reset, low
  input wire logic CHAN_A_CONTROL_IN,         // Channel A control level
  input wire logic CHAN_A_CONTROL_OPEN,       // Channel A pin floating
  input wire logic CHAN_B_CONTROL_IN,         // Channel B control level
  input wire logic CHAN_B_CONTROL_OPEN,       // Channel B pin floating
  input wire logic ENABLE_IN,                 // Enable level
  input wire logic ENABLE_OPEN,               // Enable pin floating
  input wire logic SHUTDOWN_IN_LOW_ACTIVE,    // Shutdown level
  input wire logic SHUTDOWN_OPEN,             // Shutdown pin floating
  input wire logic PRIMARY_SIDE_SUPPLY_OK,    // Input supply above lockout
  input wire logic CHAN_A_SUPPLY_OK,          // Channel A supply healthy
  input wire logic CHAN_B_SUPPLY_OK,          // Channel B supply healthy
  input wire hbg_pkg::hbg_gap_t SWITCH_GAP_DELAY, // Dead time in cycles
  output logic CHAN_A_GATE_DRIVE,             // Channel A gate drive
  output logic CHAN_B_GATE_DRIVE,             // Channel B gate drive
  output logic CHAN_A_GAP_WAIT,               // Channel A held by dead time
  output logic CHAN_B_GAP_WAIT,               // Channel B held by dead time
  output var hbg_pkg::hbg_mode_e DRIVER_MODE  // Overall driver mode
);
  import hbg_pkg::*;

  function automatic logic hbg_chan_permit(
    input logic prim_ok,
    input logic on,
    input logic own_ok
  );
    hbg_chan_permit = prim_ok & on & own_ok;
  endfunction : hbg_chan_permit

  logic [1:0] pin_eff;
  logic [1:0] in_s;
  logic [1:0] own_ok;
  logic [1:0] elapsed;
  logic [1:0] timer_clear;
  logic [1:0] gate_q;
  logic [1:0] wait_q;
  logic en_eff;
  logic shut_eff;
  logic enabled;
  logic overlap;
  hbg_gap_t gap_eff;
  hbg_mode_e mode_reg;
  hbg_mode_e mode_next;

  function automatic logic request_any();
    request_any = in_s[`HBG_CHAN_A] ^ in_s[`HBG_CHAN_B];
  endfunction : request_any

  // Floating pins take the level of their internal pull resistor
  assign pin_eff[`HBG_CHAN_A] = CHAN_A_CONTROL_OPEN ?
                                `HBG_CHAN_OPEN_LVL : CHAN_A_CONTROL_IN;
  assign pin_eff[`HBG_CHAN_B] = CHAN_B_CONTROL_OPEN ?
                                `HBG_CHAN_OPEN_LVL : CHAN_B_CONTROL_IN;
  assign en_eff = ENABLE_OPEN ? `HBG_EN_OPEN_LVL : ENABLE_IN;
  assign shut_eff = SHUTDOWN_OPEN ?
                    `HBG_SHUT_OPEN_LVL : SHUTDOWN_IN_LOW_ACTIVE;

  // Only the pair enable low with shutdown high turns the driver off;
  // the other mixed pairs keep it running
  assign enabled = en_eff | ~shut_eff;
  assign overlap = in_s[`HBG_CHAN_A] & in_s[`HBG_CHAN_B];
  assign own_ok[`HBG_CHAN_A] = CHAN_A_SUPPLY_OK;
  assign own_ok[`HBG_CHAN_B] = CHAN_B_SUPPLY_OK;

  // A zero setting would let a drive rise in the cycle the other falls
  assign gap_eff = (SWITCH_GAP_DELAY < `HBG_GAP_MIN) ?
                   `HBG_GAP_MIN : SWITCH_GAP_DELAY;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic permit;
      logic request;
      logic gate_reg;
      logic gate_next;
      logic wait_reg;

      hbg_sync u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d(pin_eff[ch]),
        .q(in_s[ch])
      );

      // Primary lockout and disable override everything; own supply
      // gates only this channel
      assign permit = hbg_chan_permit(PRIMARY_SIDE_SUPPLY_OK, enabled,
                                      own_ok[ch]);
      assign request = in_s[ch] & ~in_s[1 - ch];

      // Gap restarts while blocked or while the other side asks,
      // so recovery from the overlap clamp also waits
      assign timer_clear[ch] = ~permit | in_s[1 - ch];

      hbg_dead_timer u_timer (
        .clk(CLOCK),
        .rst_n(RST_N),
        .clear(timer_clear[ch]),
        .gap_cfg(gap_eff),
        .elapsed(elapsed[ch])
      );

      assign gate_next = permit & request & elapsed[ch];

      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          gate_reg <= `HBG_FF_RST_LVL;
        end else begin
          gate_reg <= gate_next;
        end
      end

      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          wait_reg <= `HBG_FF_RST_LVL;
        end else begin
          wait_reg <= permit & request & ~elapsed[ch];
        end
      end

      assign gate_q[ch] = gate_reg;
      assign wait_q[ch] = wait_reg;
    end
  endgenerate

  always_comb begin
    if (!PRIMARY_SIDE_SUPPLY_OK) begin
      mode_next = HBG_MODE_OFF;
    end else if (!enabled) begin
      mode_next = HBG_MODE_DISABLED;
    end else if (overlap) begin
      mode_next = HBG_MODE_OVERLAP;
    end else begin
      mode_next = HBG_MODE_RUN;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= HBG_MODE_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign CHAN_A_GATE_DRIVE = gate_q[`HBG_CHAN_A];
  assign CHAN_B_GATE_DRIVE = gate_q[`HBG_CHAN_B];
  assign CHAN_A_GAP_WAIT = wait_q[`HBG_CHAN_A];
  assign CHAN_B_GAP_WAIT = wait_q[`HBG_CHAN_B];
  assign DRIVER_MODE = mode_reg;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_a_open_held;
    CHAN_A_CONTROL_OPEN [*3];
  endsequence

  sequence s_b_open_held;
    CHAN_B_CONTROL_OPEN [*3];
  endsequence

  sequence s_both_open_run;
    ENABLE_OPEN && SHUTDOWN_OPEN && PRIMARY_SIDE_SUPPLY_OK && !overlap;
  endsequence

  a_prim_lockout_low: assert property (
    !PRIMARY_SIDE_SUPPLY_OK |=> !CHAN_A_GATE_DRIVE && !CHAN_B_GATE_DRIVE)
    else $error("gate drive high during primary lockout");

  a_lockout_overrides: assert property (
    !PRIMARY_SIDE_SUPPLY_OK && en_eff && !shut_eff && request_any()
      |=> DRIVER_MODE == HBG_MODE_OFF && gate_q == 2'h0)
    else $error("active inputs escaped the primary lockout");

  a_a_lockout_low: assert property (
    !CHAN_A_SUPPLY_OK |=> !CHAN_A_GATE_DRIVE)
    else $error("channel A drive high while its supply is low");

  a_b_lockout_low: assert property (
    !CHAN_B_SUPPLY_OK |=> !CHAN_B_GATE_DRIVE)
    else $error("channel B drive high while its supply is low");

  a_other_lockout_free: assert property (
    PRIMARY_SIDE_SUPPLY_OK && enabled && CHAN_B_SUPPLY_OK &&
    !CHAN_A_SUPPLY_OK && in_s == 2'h2 && elapsed[`HBG_CHAN_B]
      |=> CHAN_B_GATE_DRIVE)
    else $error("channel B stopped by channel A lockout");

  a_active_high_in: assert property (
    $rose(CHAN_A_GATE_DRIVE)
      |-> $past(in_s[`HBG_CHAN_A]) && $past(en_eff | ~shut_eff))
    else $error("channel A rose without its input and enable high");

  a_shutdown_low_act: assert property (
    PRIMARY_SIDE_SUPPLY_OK && !en_eff && !shut_eff
      |=> DRIVER_MODE != HBG_MODE_DISABLED)
    else $error("low shutdown level disabled the driver");

  a_shutdown_disable: assert property (
    !en_eff && shut_eff |=> !CHAN_A_GATE_DRIVE && !CHAN_B_GATE_DRIVE)
    else $error("gate drive high while disabled");

  a_a_open_low: assert property (
    s_a_open_held |=> !CHAN_A_GATE_DRIVE)
    else $error("floating channel A input drove its gate high");

  a_b_open_low: assert property (
    s_b_open_held |=> !CHAN_B_GATE_DRIVE)
    else $error("floating channel B input drove its gate high");

  a_enable_open_on: assert property (
    ENABLE_OPEN && PRIMARY_SIDE_SUPPLY_OK
      |=> DRIVER_MODE != HBG_MODE_DISABLED)
    else $error("floating enable did not read high");

  a_pins_open_run: assert property (
    s_both_open_run |=> DRIVER_MODE == HBG_MODE_RUN)
    else $error("floating on/off pins did not run the driver");

  a_rise_needs_solo: assert property (
    $rose(CHAN_B_GATE_DRIVE)
      |-> $past(!in_s[`HBG_CHAN_A]) && $past(CHAN_B_SUPPLY_OK))
    else $error("channel B rose with channel A input high");

  a_overlap_clamp: assert property (
    overlap |=> !CHAN_A_GATE_DRIVE && !CHAN_B_GATE_DRIVE)
    else $error("gate drive high during input overlap");

  a_rise_after_gap: assert property (
    $rose(CHAN_A_GATE_DRIVE) |-> $past(elapsed[`HBG_CHAN_A]) &&
      $past(!timer_clear[`HBG_CHAN_A], 2))
    else $error("channel A rose before the dead time passed");

  a_gap_wait_flag: assert property (
    CHAN_B_GAP_WAIT |-> !CHAN_B_GATE_DRIVE)
    else $error("channel B waits and drives at once");

  sequence s_overlap_end;
    overlap ##1 !overlap;
  endsequence

  a_b_active_high: assert property (
    $rose(CHAN_B_GATE_DRIVE) |-> $past(in_s[`HBG_CHAN_B]) && $past(enabled))
    else $error("channel B rose without its input and enable high");

  a_a_rise_solo: assert property (
    $rose(CHAN_A_GATE_DRIVE)
      |-> $past(!in_s[`HBG_CHAN_B]) && $past(CHAN_A_SUPPLY_OK))
    else $error("channel A rose with channel B input high");

  a_b_rise_gap: assert property (
    $rose(CHAN_B_GATE_DRIVE) |-> $past(elapsed[`HBG_CHAN_B]) &&
      $past(!timer_clear[`HBG_CHAN_B], 2))
    else $error("channel B rose before the dead time passed");

  a_a_other_free: assert property (
    PRIMARY_SIDE_SUPPLY_OK && enabled && CHAN_A_SUPPLY_OK &&
    !CHAN_B_SUPPLY_OK && in_s == 2'h1 && elapsed[`HBG_CHAN_A]
      |=> CHAN_A_GATE_DRIVE)
    else $error("channel A stopped by channel B lockout");

  a_overlap_mode: assert property (
    PRIMARY_SIDE_SUPPLY_OK && enabled && overlap
      |=> DRIVER_MODE == HBG_MODE_OVERLAP)
    else $error("overlap not reported as driver mode");

  a_disabled_mode: assert property (
    PRIMARY_SIDE_SUPPLY_OK && !en_eff && shut_eff
      |=> DRIVER_MODE == HBG_MODE_DISABLED)
    else $error("enable low with shutdown high did not disable");

  a_off_mode: assert property (
    !PRIMARY_SIDE_SUPPLY_OK |=> DRIVER_MODE == HBG_MODE_OFF)
    else $error("primary lockout not reported as driver mode");

  a_overlap_recover: assert property (
    s_overlap_end |=> !CHAN_A_GATE_DRIVE && !CHAN_B_GATE_DRIVE)
    else $error("gate drive rose without dead time after overlap");

endmodule : hbg_gate_ctrl
`default_nettype wire

/* design/hbg_map.svh */
/*
  Named constants of the half-bridge gate control logic: widths, default
  levels of floating pins, counter limits.
  Assumes it is included by bare name and may be included more than once.
*/
`ifndef HBG_MAP_SVH
`define HBG_MAP_SVH

`define HBG_GAP_W 8
`define HBG_MODE_W 2
`define HBG_GAP_MIN 8'h01
`define HBG_GAP_SAT 8'hff
`define HBG_CNT_ZERO 8'h00
`define HBG_CNT_ONE 8'h01
`define HBG_CHAN_OPEN_LVL 1'b0
`define HBG_EN_OPEN_LVL 1'b1
`define HBG_SHUT_OPEN_LVL 1'b0
`define HBG_FF_RST_LVL 1'b0
`define HBG_CHAN_A 0
`define HBG_CHAN_B 1

`endif

/* design/hbg_pkg.sv */
/*
  Types shared by the gate control logic: dead-time count and driver mode.
  Assumes hbg_map.svh is on the include path.
*/
`include "hbg_map.svh"

package hbg_pkg;

  typedef logic [`HBG_GAP_W-1:0] hbg_gap_t;

  typedef enum logic [`HBG_MODE_W-1:0] {
    HBG_MODE_OFF      = 2'h0,
    HBG_MODE_DISABLED = 2'h1,
    HBG_MODE_OVERLAP  = 2'h2,
    HBG_MODE_RUN      = 2'h3
  } hbg_mode_e;

endpackage : hbg_pkg

/* design/hbg_sync.sv */
/*
  Two-flop synchroniser for one control pin.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbg_map.svh"

module hbg_sync (
  input wire logic clk,   // Internal clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic d,     // Pin level
  output logic q          // Synchronised level
);
  logic sync_1_reg;
  logic sync_2_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_1_reg <= `HBG_FF_RST_LVL;
      sync_2_reg <= `HBG_FF_RST_LVL;
    end else begin
      sync_1_reg <= d;
      sync_2_reg <= sync_1_reg;
    end
  end

  assign q = sync_2_reg;

  a_sync_two_stage: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 ##2 1'b1 |-> q == $past(d, 2))
    else $error("synchroniser output is not the pin level two edges back");

endmodule : hbg_sync
`default_nettype wire

/* design/hbg_dead_timer.sv */
/*
  Dead-time counter of one channel: counts clock cycles since the last
  clear and reports when the configured gap has passed.
  Assumes gap_cfg is at least one; the top enforces that floor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbg_map.svh"

module hbg_dead_timer (
  input wire logic clk,                 // Internal clock
  input wire logic rst_n,               // Asynchronous reset, active low
  input wire logic clear,               // Restart the gap count
  input wire hbg_pkg::hbg_gap_t gap_cfg, // Gap length in cycles
  output logic elapsed                  // Gap has passed since clear
);
  import hbg_pkg::*;

  hbg_gap_t cnt_reg;
  hbg_gap_t cnt_next;

  // Saturates so a long quiet time never wraps into a fresh wait
  always_comb begin
    if (clear) begin
      cnt_next = `HBG_CNT_ZERO;
    end else if (cnt_reg != `HBG_GAP_SAT) begin
      cnt_next = cnt_reg + `HBG_CNT_ONE;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `HBG_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Counting from the other side's release makes the gap the longer of
  // the configured time and the gap already present at the inputs
  assign elapsed = (cnt_reg >= gap_cfg) & ~clear;

  a_gap_clear_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    clear |=> cnt_reg == `HBG_CNT_ZERO)
    else $error("gap counter not restarted by clear");

  a_gap_exact_wait: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(elapsed) && $stable(gap_cfg) && $past(!clear)
      |-> cnt_reg == gap_cfg)
    else $error("gap reported before or after the configured count");

endmodule : hbg_dead_timer
`default_nettype wire

/* tb/hbg_pwm_model.sv */
/*
  Behavioural model of the digital controller driving the gate control pins.
  Assumes the bench calls its tasks; pins change 1 ns after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module hbg_pwm_model (
  input wire logic clk, // Design clock
  output logic chan_a,  // Channel A level
  output logic chan_b,  // Channel B level
  output logic open_a,  // Channel A floating
  output logic open_b,  // Channel B floating
  output logic en,      // Enable level
  output logic en_open, // Enable floating
  output logic shut,    // Shutdown level
  output logic sh_open  // Shutdown floating
);
  // Both on/off pins actively driven by default, never floated unasked
  initial begin
    {chan_a, chan_b, open_a, open_b} = 4'h0;
    {en, en_open, shut, sh_open} = 4'h8;
  end

  task automatic set_chan(input logic a, input logic b);
    @(posedge clk);
    #1;
    chan_a = a;
    chan_b = b;
  endtask : set_chan

  task automatic set_onoff(input logic e, input logic s);
    @(posedge clk);
    #1;
    en = e;
    shut = s;
  endtask : set_onoff

  task automatic set_open(input logic [3:0] o);
    @(posedge clk);
    #1;
    {open_a, open_b, en_open, sh_open} = o;
  endtask : set_open
endmodule : hbg_pwm_model
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench of the gate control logic with a controller model.
  Assumes the design files are compiled first; dead time set to 3 cycles, later 6.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import hbg_pkg::*;
  localparam int G = 3;
  localparam int G2 = 6;
  logic clk, rst_n, p_ok, a_ok, b_ok;
  logic ia, ib, oa, ob, en, eo, sh, so, da, db, wa, wb;
  hbg_mode_e mode;
  hbg_gap_t gap;
  int miscompares = 0;
  int num_checks = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  hbg_pwm_model pwm (.clk(clk), .chan_a(ia), .chan_b(ib), .open_a(oa),
    .open_b(ob), .en(en), .en_open(eo), .shut(sh), .sh_open(so));

  hbg_gate_ctrl dut (.CLOCK(clk), .RST_N(rst_n), .CHAN_A_CONTROL_IN(ia),
    .CHAN_A_CONTROL_OPEN(oa), .CHAN_B_CONTROL_IN(ib),
    .CHAN_B_CONTROL_OPEN(ob), .ENABLE_IN(en), .ENABLE_OPEN(eo),
    .SHUTDOWN_IN_LOW_ACTIVE(sh), .SHUTDOWN_OPEN(so),
    .PRIMARY_SIDE_SUPPLY_OK(p_ok), .CHAN_A_SUPPLY_OK(a_ok),
    .CHAN_B_SUPPLY_OK(b_ok), .SWITCH_GAP_DELAY(gap),
    .CHAN_A_GATE_DRIVE(da), .CHAN_B_GATE_DRIVE(db), .CHAN_A_GAP_WAIT(wa),
    .CHAN_B_GAP_WAIT(wb), .DRIVER_MODE(mode));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic sup(input logic [2:0] v);
    @(posedge clk);
    #1;
    {p_ok, a_ok, b_ok} = v;
  endtask : sup

  task automatic check(input string nm, input logic [1:0] seen,
                       input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is well under 400 cycles
  initial begin
    #10000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    gap = 8'h03;
    {p_ok, a_ok, b_ok} = 3'h7;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    step(8);
    check("drive a idle", {1'b0, da}, 2'h0);
    pwm.set_chan(1'b1, 1'b0);
    step(2);
    check("drive a early", {1'b0, da}, 2'h0);
    step(1);
    check("drive a on", {1'b0, da}, 2'h1);
    check("drive b off", {1'b0, db}, 2'h0);
    pwm.set_chan(1'b1, 1'b1);
    step(3);
    check("overlap a", {1'b0, da}, 2'h0);
    check("overlap b", {1'b0, db}, 2'h0);
    check("overlap mode", mode, HBG_MODE_OVERLAP);
    pwm.set_chan(1'b1, 1'b0);
    step(G + 2);
    check("recover a early", {1'b0, da}, 2'h0);
    check("gap wait a", {1'b0, wa}, 2'h1);
    step(1);
    check("recover a", {1'b0, da}, 2'h1);
    pwm.set_chan(1'b0, 1'b0);
    step(10);
    pwm.set_chan(1'b0, 1'b1);
    step(3);
    check("long input gap b", {1'b0, db}, 2'h1);
    check("gap wait b", {1'b0, wb}, 2'h0);
    pwm.set_chan(1'b1, 1'b0);
    step(12);
    sup(3'h5);
    step(1);
    check("lockout a", {1'b0, da}, 2'h0);
    check("run mode", mode, HBG_MODE_RUN);
    pwm.set_chan(1'b0, 1'b1);
    step(G + 6);
    check("b during a lockout", {1'b0, db}, 2'h1);
    sup(3'h7);
    sup(3'h6);
    step(1);
    check("lockout b", {1'b0, db}, 2'h0);
    sup(3'h7);
    step(G - 1);
    check("supply recover early", {1'b0, db}, 2'h0);
    step(3);
    check("supply recover", {1'b0, db}, 2'h1);
    sup(3'h3);
    pwm.set_onoff(1'b0, 1'b1);
    sup(3'h0);
    step(1);
    check("primary off b", {1'b0, db}, 2'h0);
    check("primary off mode", mode, HBG_MODE_OFF);
    pwm.set_chan(1'b1, 1'b0);
    pwm.set_onoff(1'b1, 1'b0);
    step(G + 4);
    check("primary off a", {1'b0, da}, 2'h0);
    sup(3'h7);
    step(G + 4);
    check("primary back a", {1'b0, da}, 2'h1);
    for (int i = 0; i < 4; i++) begin
      pwm.set_onoff(i[1], i[0]);
      step(G + 4);
      check("onoff drive", {1'b0, da}, {1'b0, i[1] | ~i[0]});
      check("onoff mode", mode,
            (i == 1) ? HBG_MODE_DISABLED : HBG_MODE_RUN);
    end
    pwm.set_onoff(1'b0, 1'b1);
    pwm.set_open(4'h3);
    step(G + 4);
    check("floating onoff", {1'b0, da}, 2'h1);
    pwm.set_open(4'hb);
    step(3);
    check("floating chan a", {1'b0, da}, 2'h0);
    pwm.set_chan(1'b0, 1'b1);
    pwm.set_open(4'h3);
    step(G + 6);
    check("chan b released", {1'b0, db}, 2'h1);
    pwm.set_open(4'h7);
    step(3);
    check("floating chan b", {1'b0, db}, 2'h0);
    pwm.set_open(4'h3);
    gap = 8'h06;
    step(G2 + 3);
    check("drive b long gap", {1'b0, db}, 2'h1);
    pwm.set_chan(1'b1, 1'b0);
    step(G2 + 2);
    check("long gap a early", {1'b0, da}, 2'h0);
    check("long gap wait a", {1'b0, wa}, 2'h1);
    step(1);
    check("long gap a", {1'b0, da}, 2'h1);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
